// *** rx_clock_level_acquisition.sv ***
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module rx_clock_level_acquisition #(
   parameter int quality_width = 8
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [1:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_write,
   input wire logic bus_read,
   output logic [7:0] bus_rdata,
   output logic irq,
   input wire logic symbol_tick_pin,
   input wire logic frame_sync_found_pin,
   input wire logic task_done_pin,
   input wire logic rx_symbol_pin,
   input wire logic rx_outer_pin,
   output logic [2:0] pll_mode,
   output logic [2:0] level_mode,
   output logic peak_filter_en
);
   initial begin
      if (quality_width < 2 || quality_width > 8) begin
         $error("quality_width out of range");
      end
   end
   // pin synchronisers, first stage read only by second
   logic [4:0] sync1_r;
   logic [4:0] sync2_r;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sync1_r <= 5'h00;
         sync2_r <= 5'h00;
      end else begin
         sync1_r <= {rx_outer_pin, rx_symbol_pin, task_done_pin,
                     frame_sync_found_pin, symbol_tick_pin};
         sync2_r <= sync1_r;
      end
   end
   logic tick_d_r;
   logic sync_d_r;
   logic done_d_r;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         tick_d_r <= 1'b0;
         sync_d_r <= 1'b0;
         done_d_r <= 1'b0;
      end else begin
         tick_d_r <= sync2_r[0];
         sync_d_r <= sync2_r[1];
         done_d_r <= sync2_r[2];
      end
   end
   logic sym_tick;
   logic sync_evt;
   logic done_evt;
   assign sym_tick = sync2_r[0] & ~tick_d_r;
   assign sync_evt = sync2_r[1] & ~sync_d_r;
   assign done_evt = sync2_r[2] & ~done_d_r;
   // registers
   logic [7:0] control_r;
   logic [7:0] mask_r;
   logic [7:0] status_r;
   logic cmd_wr;
   logic arm_clk;
   logic arm_lev;
   logic search_task;
   assign cmd_wr = bus_write && bus_addr == acq_pkg::adr_command;
   assign search_task =
      bus_wdata[acq_pkg::task_lsb +: acq_pkg::task_w]
         == acq_pkg::frame_sync_search_task ||
      bus_wdata[acq_pkg::task_lsb +: acq_pkg::task_w]
         == acq_pkg::frame_sync_header_task;
   // either bit arms its own sequence on any search task
   assign arm_clk = cmd_wr && search_task &&
      bus_wdata[acq_pkg::symbol_clock_acquire_bit];
   assign arm_lev = cmd_wr && search_task &&
      bus_wdata[acq_pkg::level_acquire_bit];
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         control_r <= acq_pkg::control_reset;
      end else if (bus_write && bus_addr == acq_pkg::adr_control) begin
         control_r <= bus_wdata;
      end
   end
   // mask shares the command address high nibble-free space: write
   // to status address sets the mask since status is read-only
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         mask_r <= 8'h00;
      end else if (bus_write && bus_addr == acq_pkg::adr_status) begin
         mask_r <= bus_wdata;
      end
   end
   // level sequence
   typedef enum logic [1:0] {lv_idle, lv_clamp, lv_lossy, lv_slow} lv_t;
   lv_t lv_r;
   logic [4:0] lv_cnt_r;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         lv_r <= lv_idle;
         lv_cnt_r <= 5'h00;
      end else if (arm_lev) begin
         lv_r <= lv_clamp;
         lv_cnt_r <= 5'h00;
      end else begin
         case (lv_r)
            lv_idle: lv_cnt_r <= 5'h00;
            lv_clamp: if (sym_tick) begin
               lv_r <= lv_lossy;
               lv_cnt_r <= 5'h00;
            end
            lv_lossy: if (sym_tick) begin
               if (lv_cnt_r == 5'(acq_pkg::lossy_symbols - 1)) begin
                  lv_r <= lv_slow;
                  lv_cnt_r <= 5'h00;
               end else begin
                  lv_cnt_r <= lv_cnt_r + 5'h01;
               end
            end
            lv_slow: if (sync_evt) begin
               lv_r <= lv_idle;
            end
            default: lv_r <= lv_idle;
         endcase
      end
   end
   // clock sequence
   typedef enum logic [1:0] {ck_idle, ck_extra, ck_wide} ck_t;
   ck_t ck_r;
   logic [5:0] ck_cnt_r;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ck_r <= ck_idle;
         ck_cnt_r <= 6'h00;
      end else if (arm_clk) begin
         ck_r <= ck_extra;
         ck_cnt_r <= 6'h00;
      end else begin
         case (ck_r)
            ck_idle: ck_cnt_r <= 6'h00;
            ck_extra: if (sym_tick) begin
               if (ck_cnt_r == 6'(acq_pkg::extra_wide_symbols - 1)) begin
                  ck_r <= ck_wide;
                  ck_cnt_r <= 6'h00;
               end else begin
                  ck_cnt_r <= ck_cnt_r + 6'h01;
               end
            end
            ck_wide: if (sym_tick) begin
               if (ck_cnt_r == 6'(acq_pkg::wide_symbols - 1)) begin
                  ck_r <= ck_idle;
                  ck_cnt_r <= 6'h00;
               end else begin
                  ck_cnt_r <= ck_cnt_r + 6'h01;
               end
            end
            default: ck_r <= ck_idle;
         endcase
      end
   end
   // mode outputs, registered; the 2-bit control field never reaches extra wide
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pll_mode <= 3'(acq_pkg::pll_narrow);
         level_mode <= 3'(acq_pkg::lev_track);
         peak_filter_en <= 1'b0;
      end else begin
         case (ck_r)
            ck_extra: pll_mode <= 3'(acq_pkg::pll_extra_wide);
            ck_wide: pll_mode <= 3'(acq_pkg::pll_wide);
            default: pll_mode <=
               {1'b0, control_r[acq_pkg::pll_bw_lsb +: 2]};
         endcase
         case (lv_r)
            lv_clamp: level_mode <= 3'(acq_pkg::lev_clamp);
            lv_lossy: level_mode <= 3'(acq_pkg::lev_lossy);
            lv_slow: level_mode <= 3'(acq_pkg::lev_slow);
            default: level_mode <=
               {1'b0, control_r[acq_pkg::level_res_lsb +: 2]};
         endcase
         // low pass ahead of peak detect keeps pattern noise off caps
         peak_filter_en <= lv_r == lv_lossy || lv_r == lv_slow;
      end
   end
   // data quality, scored from outer-symbol agreement
   logic [quality_width-1:0] quality;
   quality_meter #(.width(quality_width)) u_quality (
      .mclk(mclk),
      .reset_n(reset_n),
      .symbol_tick(sym_tick),
      .sample_good(sync2_r[3] ~^ sync2_r[4]),
      .quality(quality)
   );
   // status: sticky events, cleared by read, set wins
   logic st_read;
   assign st_read = bus_read && bus_addr == acq_pkg::adr_status;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         status_r <= 8'h00;
      end else begin
         status_r[acq_pkg::st_sync_bit] <= sync_evt ||
            (status_r[acq_pkg::st_sync_bit] && !st_read);
         status_r[acq_pkg::st_task_done_bit] <= done_evt ||
            (status_r[acq_pkg::st_task_done_bit] && !st_read);
      end
   end
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_r & mask_r);
      end
   end
   logic [7:0] status_view;
   always_comb begin
      status_view = status_r;
      status_view[acq_pkg::st_lev_busy_bit] = lv_r != lv_idle;
      status_view[acq_pkg::st_clk_busy_bit] = ck_r != ck_idle;
   end
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         bus_rdata <= 8'h00;
      end else if (bus_read) begin
         case (bus_addr)
            acq_pkg::adr_command: bus_rdata <= mask_r;
            acq_pkg::adr_control: bus_rdata <= control_r;
            acq_pkg::adr_status: bus_rdata <= status_view;
            acq_pkg::adr_quality: bus_rdata <= 8'(quality);
            default: bus_rdata <= 8'h00;
         endcase
      end else begin
         bus_rdata <= 8'h00;
      end
   end
endmodule : rx_clock_level_acquisition

// *** acq_pkg.sv ***
package acq_pkg;
   // register addresses and command register layout
   localparam logic [1:0] adr_command = 2'h0;
   localparam logic [1:0] adr_control = 2'h1;
   localparam logic [1:0] adr_status = 2'h2;
   localparam logic [1:0] adr_quality = 2'h3;
   localparam int task_lsb = 0;
   localparam int task_w = 3;
   localparam logic [2:0] frame_sync_search_task = 3'h1;
   localparam logic [2:0] frame_sync_header_task = 3'h2;
   localparam int symbol_clock_acquire_bit = 6;
   localparam int level_acquire_bit = 7;
   // control register layout
   localparam int pll_bw_lsb = 0;
   localparam int level_res_lsb = 2;
   localparam logic [7:0] control_reset = 8'h00;
   // pll bandwidth codes; extra wide is internal only
   typedef enum logic [2:0] {
      pll_narrow, pll_medium, pll_wide, pll_spare, pll_extra_wide
   } pll_mode_t;
   // level measurement codes
   typedef enum logic [2:0] {
      lev_track, lev_hold, lev_fast, lev_spare,
      lev_clamp, lev_lossy, lev_slow
   } lev_mode_t;
   // phase lengths in symbol times
   localparam int clamp_symbols = 1;
   localparam int lossy_symbols = 15;
   localparam int extra_wide_symbols = 16;
   localparam int wide_symbols = 45;
   // status bit positions
   localparam int st_sync_bit = 0;
   localparam int st_task_done_bit = 1;
   localparam int st_lev_busy_bit = 4;
   localparam int st_clk_busy_bit = 5;
endpackage : acq_pkg

// *** quality_meter.sv ***
`timescale 1ns/1ps
module quality_meter #(
   parameter int width = 8
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic symbol_tick,
   input wire logic sample_good,
   output logic [width-1:0] quality
);
   initial begin
      if (width < 2) begin
         $error("quality width too small");
      end
   end
   logic [width-1:0] quality_r;
   // leaky score: up on good symbol, down on bad
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         quality_r <= '0;
      end else if (symbol_tick) begin
         if (sample_good && quality_r != {width{1'b1}}) begin
            quality_r <= quality_r + 1'b1;
         end else if (!sample_good && quality_r != '0) begin
            quality_r <= quality_r - 1'b1;
         end
      end
   end
   assign quality = quality_r;
endmodule : quality_meter

// *** acq_checker.sv ***
`timescale 1ns/1ps
module acq_checker (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [1:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_write,
   input wire logic bus_read,
   input wire logic [7:0] bus_rdata,
   input wire logic irq,
   input wire logic [2:0] pll_mode,
   input wire logic [2:0] level_mode,
   input wire logic peak_filter_en
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   logic cmd, clk_arm, st_acc;
   // only the two search tasks arm a sequence
   assign cmd = bus_write && bus_addr == acq_pkg::adr_command &&
      (bus_wdata[acq_pkg::task_lsb +: acq_pkg::task_w]
         == acq_pkg::frame_sync_search_task ||
       bus_wdata[acq_pkg::task_lsb +: acq_pkg::task_w]
         == acq_pkg::frame_sync_header_task);
   assign clk_arm = cmd && bus_wdata[acq_pkg::symbol_clock_acquire_bit];
   assign st_acc = (bus_read || bus_write) && bus_addr == acq_pkg::adr_status;
   sequence arm_lev;
      cmd && bus_wdata[acq_pkg::level_acquire_bit];
   endsequence
   sequence arm_clk;
      clk_arm;
   endsequence
   clamp_start_a: assert property (arm_lev |-> ##2 level_mode == 3'h4)
      else $error("clamp not entered");
   extra_start_a: assert property (arm_clk |-> ##2 pll_mode == 3'h4)
      else $error("extra wide not entered");
   extra_cause_a: assert property ($rose(pll_mode == 3'h4) |->
      $past(clk_arm, 2)) else $error("extra wide without arming");
   lossy_entry_a: assert property ($rose(level_mode == 3'h5) |->
      $past(level_mode) == 3'h4) else $error("lossy not after clamp");
   slow_entry_a: assert property ($rose(level_mode == 3'h6) |->
      $past(level_mode) == 3'h5) else $error("slow not after lossy");
   wide_after_a: assert property ($fell(pll_mode == 3'h4) |->
      pll_mode == 3'h2) else $error("wide not after extra wide");
   filter_tie_a: assert property (peak_filter_en ==
      (level_mode inside {3'h5, 3'h6})) else $error("peak filter wrong");
   rdata_idle_a: assert property (!$past(bus_read) |->
      bus_rdata == 8'h00) else $error("read data outside slot");
   irq_clear_a: assert property ($fell(irq) |->
      $past(st_acc) || $past(st_acc, 2)) else $error("irq dropped alone");
endmodule : acq_checker
bind rx_clock_level_acquisition acq_checker u_chk (.mclk(mclk),
   .reset_n(reset_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
   .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
   .irq(irq), .pll_mode(pll_mode), .level_mode(level_mode),
   .peak_filter_en(peak_filter_en));

// *** rx_source.sv ***
`timescale 1ns/1ps
module rx_source (
   input wire logic mclk,
   input wire logic run,
   input wire logic [3:0] period,
   input wire logic good,
   output logic symbol_tick_pin,
   output logic frame_sync_found_pin,
   output logic task_done_pin,
   output logic rx_symbol_pin,
   output logic rx_outer_pin,
   output int tick_count
);
   logic s;
   initial begin
      {symbol_tick_pin, frame_sync_found_pin, task_done_pin} = 3'h0;
      {rx_symbol_pin, rx_outer_pin} = 2'h0;
      tick_count = 0;
   end
   // no carrier, no ticks: recovered clock stands still
   always begin
      @(posedge mclk);
      if (run) begin
         s = 1'($urandom);
         rx_symbol_pin <= s;
         rx_outer_pin <= good ? s : ~s;
         @(posedge mclk);
         symbol_tick_pin <= 1'b1;
         tick_count <= tick_count + 1;
         repeat (2) @(posedge mclk);
         symbol_tick_pin <= 1'b0;
         repeat (period - 4) @(posedge mclk);
      end
   end
   task automatic pulse(input bit done);
      @(posedge mclk);
      if (done) task_done_pin <= 1'b1;
      else frame_sync_found_pin <= 1'b1;
      repeat (2) @(posedge mclk);
      {task_done_pin, frame_sync_found_pin} <= 2'h0;
   endtask : pulse
endmodule : rx_source

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic [1:0] bus_addr = 2'h0;
   logic [7:0] bus_wdata = 8'h00;
   logic bus_write = 1'b0;
   logic bus_read = 1'b0;
   logic run = 1'b0;
   logic good = 1'b1;
   logic [3:0] period = 4'h8;
   logic [7:0] bus_rdata, rd, qa;
   logic irq, tick, fsync, tdone, sym, outer, filt;
   logic [2:0] pll_mode, level_mode;
   int n_fail = 0;
   int comparisons = 0;
   int tick_count, a, b;
   initial begin
      forever #25 mclk = ~mclk;
   end
   rx_clock_level_acquisition u_dut (.mclk(mclk), .reset_n(reset_n),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write),
      .bus_read(bus_read), .bus_rdata(bus_rdata), .irq(irq),
      .symbol_tick_pin(tick), .frame_sync_found_pin(fsync),
      .task_done_pin(tdone), .rx_symbol_pin(sym), .rx_outer_pin(outer),
      .pll_mode(pll_mode), .level_mode(level_mode), .peak_filter_en(filt));
   rx_source u_src (.mclk(mclk), .run(run), .period(period), .good(good),
      .symbol_tick_pin(tick), .frame_sync_found_pin(fsync),
      .task_done_pin(tdone), .rx_symbol_pin(sym), .rx_outer_pin(outer),
      .tick_count(tick_count));
   task automatic wr(input logic [1:0] ad, input logic [7:0] d);
      @(posedge mclk);
      bus_addr <= ad;
      bus_wdata <= d;
      bus_write <= 1'b1;
      @(posedge mclk);
      bus_write <= 1'b0;
   endtask : wr
   task automatic rdr(input logic [1:0] ad);
      @(posedge mclk);
      bus_addr <= ad;
      bus_read <= 1'b1;
      @(posedge mclk);
      bus_read <= 1'b0;
      #1 rd = bus_rdata;
   endtask : rdr
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   // sel 0 level, 1 pll, 2 irq
   task automatic wv(input int sel, input logic [2:0] m);
      for (int i = 0; i < 4000; i++) begin
         @(posedge mclk);
         #1;
         if ((sel == 0 ? level_mode : sel == 1 ? pll_mode : {2'h0, irq})
            === m) break;
      end
   endtask : wv
   task automatic wt(input int n);
      int e;
      e = tick_count + n;
      while (tick_count < e) @(posedge mclk);
   endtask : wt
   task automatic print_verdict;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : print_verdict
   initial begin
      #2000000;
      n_fail++;
      print_verdict();
   end
   initial begin
      void'($urandom(7));
      period <= 4'($urandom_range(8, 12));
      repeat (6) @(posedge mclk);
      reset_n <= 1'b1;
      wr(acq_pkg::adr_control, 8'h02);
      wr(acq_pkg::adr_status, 8'h03);
      rdr(acq_pkg::adr_command);
      chk(rd, 8'h03);
      run <= 1'b1;
      wt(8);
      rdr(acq_pkg::adr_quality);
      qa = rd;
      good <= 1'b0;
      wt(64);
      rdr(acq_pkg::adr_quality);
      chk({7'h0, rd < qa || qa == 8'h00}, 8'h01);
      chk({7'h0, qa < 8'd50 && rd < 8'd50}, 8'h01);
      good <= 1'b1;
      // arm away from a tick so the first counted tick is unambiguous
      wt(100);
      repeat (3) @(posedge mclk);
      wr(acq_pkg::adr_command, 8'hc1);
      fork
         begin
            wv(0, 3'h5);
            a = tick_count;
            wv(0, 3'h6);
            chk(8'(tick_count - a), 8'h0f);
            wt(3);
            u_src.pulse(1'b0);
            wv(2, 3'h1);
            rdr(acq_pkg::adr_status);
            chk(rd & 8'h03, 8'h01);
            wr(acq_pkg::adr_control, 8'h01);
            rdr(acq_pkg::adr_status);
            chk(rd & 8'h03, 8'h00);
            chk({7'h0, irq}, 8'h00);
            wv(0, 3'h0);
            chk({5'h0, level_mode}, 8'h00);
         end
         begin
            wv(1, 3'h4);
            b = tick_count;
            wv(1, 3'h2);
            chk(8'(tick_count - b), 8'h10);
            b = tick_count;
            wv(1, 3'h1);
            chk(8'(tick_count - b), 8'h2d);
         end
      join
      wr(acq_pkg::adr_command, 8'hc2);
      wv(0, 3'h5);
      wt(5);
      wr(acq_pkg::adr_command, 8'hc2);
      wv(0, 3'h4);
      wv(0, 3'h5);
      a = tick_count;
      wv(0, 3'h6);
      chk(8'(tick_count - a), 8'h0f);
      wr(acq_pkg::adr_command, 8'h01);
      repeat (3) @(posedge mclk);
      chk({5'h0, level_mode}, 8'h06);
      u_src.pulse(1'b1);
      wv(2, 3'h1);
      rdr(acq_pkg::adr_status);
      chk(rd & 8'h03, 8'h02);
      print_verdict();
   end
endmodule : tb_top
